/* core/lasc_fifo.sv */
// Purpose: Sample buffer between host readout and its user
// Assumes: One clock; push and pop in the same cycle allowed
// Notes: in_ready low stalls the pixel clock in the host

`timescale 1ns/1ps

module lasc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Fill counter is one bit wider so full stays distinct from empty
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : lasc_fifo

/* core/lasc_host.sv */
// Purpose: Host controller end: makes pixel clock, start, freeze; samples
// Assumes: Sensor output settles within a half pixel clock
// Notes: A full buffer holds the pixel clock low until room returns

`timescale 1ns/1ps

module lasc_host
  import lasc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the sensor
  lasc_link_if.host link,
  // Scan request
  input wire logic start_req,
  output logic start_ready,
  output logic scan_done,
  // Sample stream
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [LEVEL_W-1:0] sample_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock divider

  lasc_host_state_t state, next_state;
  logic [DIV_W-1:0] div;
  logic [COUNT_W-1:0] rises;
  logic [TRANSFER_W-1:0] wait_cnt;
  logic fifo_in_ready;

  wire half_done = (div == DIV_W'(PIX_HALF_CYC - 1));
  wire scanning = (state == LASC_ARM) || (state == LASC_SCAN);
  // Rise gated by buffer room: back-pressure stalls the scan
  wire rise_ok = scanning && fifo_in_ready;
  wire do_rise = half_done && !link.pix_clk && rise_ok;
  wire do_fall = half_done && link.pix_clk;
  wire in_pixel = (rises >= CNT_FIRST) && (rises <= CNT_LAST_PIXEL);
  wire take_sample = do_rise && in_pixel && link.aout_oe;
  wire final_rise = do_rise && (rises == CNT_LAST_PIXEL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
      link.pix_clk <= 1'b0;
    end else if (half_done) begin
      if (link.pix_clk || rise_ok) begin
        div <= '0;
        link.pix_clk <= !link.pix_clk;
      end
    end else begin
      div <= div + DIV_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequence

  wire xfer_done = (wait_cnt == TRANSFER_W'(TRANSFER_CYC - 1));

  always_comb begin
    next_state = state;
    case (state)
      LASC_IDLE: begin
        if (start_req) next_state = LASC_ARM;
      end
      LASC_ARM: begin
        if (do_rise) next_state = LASC_SCAN;
      end
      LASC_SCAN: begin
        if (final_rise) next_state = LASC_XFER;
      end
      LASC_XFER: begin
        if (xfer_done) next_state = LASC_IDLE;
      end
      default: next_state = LASC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LASC_IDLE;
      rises <= CNT_IDLE;
      wait_cnt <= '0;
      link.scan_start <= 1'b0;
      link.hold_freeze <= 1'b0;
      start_ready <= 1'b1;
      scan_done <= 1'b0;
    end else begin
      state <= next_state;
      if (state == LASC_IDLE) rises <= CNT_IDLE;
      else if (do_rise && state != LASC_XFER) rises <= rises + COUNT_W'(1);
      wait_cnt <= (state == LASC_XFER) ? wait_cnt + TRANSFER_W'(1) : '0;
      // Start raised as the request is taken in idle, before the first rise; dropped at the fall
      if (state == LASC_IDLE && start_req) begin
        link.scan_start <= 1'b1;
        link.hold_freeze <= 1'b1;
      end else if (do_fall) begin
        link.scan_start <= 1'b0;
        link.hold_freeze <= 1'b0;
      end
      start_ready <= (next_state == LASC_IDLE);
      scan_done <= (state == LASC_XFER) && xfer_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer

  lasc_fifo #(
    .WIDTH(LEVEL_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(take_sample),
    .in_ready(fifo_in_ready),
    .in_data(link.pixel_analog_out),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(sample_data)
  );

endmodule : lasc_host

/* core/lasc_link_if.sv */
// Purpose: Pins between the sensor array end and its host controller
// Assumes: Both ends run on sys_clk; pins reach the sensor unsynchronised
// Notes: Analog output is a level word with an output enable

`timescale 1ns/1ps

interface lasc_link_if;
  import lasc_pkg::*;

  logic pix_clk;
  logic scan_start;
  logic hold_freeze;
  logic [LEVEL_W-1:0] pixel_analog_out;
  logic aout_oe;
  logic chain_out;

  modport sensor (
    input pix_clk,
    input scan_start,
    input hold_freeze,
    output pixel_analog_out,
    output aout_oe,
    output chain_out
  );

  modport host (
    output pix_clk,
    output scan_start,
    output hold_freeze,
    input pixel_analog_out,
    input aout_oe,
    input chain_out
  );

endinterface : lasc_link_if

/* core/lasc_pkg.sv */
// Purpose: Shared constants for the linear array scan control ends
// Assumes: One 50 MHz system clock on both ends
// Notes: Pixel clock is made by the host from the system clock

package lasc_pkg;

  // System clock
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned SYS_PERIOD_NS = 20;

  // Array geometry
  localparam int unsigned PIXEL_COUNT = 128;
  localparam int unsigned COUNT_W = 8;
  localparam int unsigned INDEX_W = 7;
  localparam int unsigned LEVEL_W = 8;

  // Readout sequence, in pixel clocks
  localparam logic [COUNT_W-1:0] CNT_IDLE = 8'h00;
  localparam logic [COUNT_W-1:0] CNT_FIRST = 8'h01;
  localparam logic [COUNT_W-1:0] CNT_LAST_PIXEL = 8'h80;
  localparam logic [COUNT_W-1:0] CNT_RESET_LAST = 8'h12;
  localparam logic [COUNT_W-1:0] CNT_INTEG_START = 8'h13;

  // Pixel charge transfer time, least, rounded up to cycles
  localparam int unsigned TRANSFER_NS = 20_000;
  localparam int unsigned TRANSFER_CYC =
    (TRANSFER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned TRANSFER_W = 11;

  // Pixel clock half period in system cycles (1 MHz pixel clock)
  localparam int unsigned PIX_HALF_CYC = 25;
  localparam int unsigned DIV_W = 5;

  // Host buffer
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    LASC_IDLE = 2'b00,
    LASC_ARM = 2'b01,
    LASC_SCAN = 2'b10,
    LASC_XFER = 2'b11
  } lasc_host_state_t;

endpackage : lasc_pkg

/* core/lasc_sensor.sv */
// Purpose: Sensor array end: scan start, freeze, readout shift, chain out
// Assumes: Pixel clock, start and freeze arrive from pins, async to sys_clk
// Notes: Analog level stands for the pixel charge; oe marks output phase
//
// How it works
// - A 1 on start at clock rise begins readout
// - Host drops start before next clock rise
// - Host ties freeze to start
// - Freeze rise disconnects all capacitors, starts reset
// - 128-bit shift register steps pixels to output
// - Integrators reset 18 clocks; integrate from 19th
// - 129th rise ends scan, tristates output, clears logic; here oe drops and the level is held at zero
// - Host sends a 129th clock pulse
// - Next start no sooner than transfer time after
// - Output high impedance outside pixel output phase; here the level is driven to zero with oe low
// - Chain output can feed another start input
// - Capacitor stays on integrator until freeze
// - Host waits at least 20 us transfer time
// - Least integration is 110 clocks plus transfer

`timescale 1ns/1ps

module lasc_sensor
  import lasc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the host controller
  lasc_link_if.sensor link,
  // Pixel charge source
  output logic [INDEX_W-1:0] pixel_index,
  input wire logic [LEVEL_W-1:0] pixel_level,
  // Array state
  output logic integ_reset,
  output logic cap_connected,
  output logic scan_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two stages on start; clock and freeze add a third, read with the second for edges
  logic clk_s1, clk_s2, clk_s3;
  logic start_s1, start_s2;
  logic hold_s1, hold_s2, hold_s3;

  // Pins idle low, so clearing to low avoids a false edge after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end else begin
      clk_s1 <= link.pix_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
    end else begin
      start_s1 <= link.scan_start;
      start_s2 <= start_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
      hold_s3 <= 1'b0;
    end else begin
      hold_s1 <= link.hold_freeze;
      hold_s2 <= hold_s1;
      hold_s3 <= hold_s2;
    end
  end

  wire pclk_rise = clk_s2 && !clk_s3;
  wire hold_rise = hold_s2 && !hold_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Readout sequence

  logic [PIXEL_COUNT-1:0] shift;
  logic [COUNT_W-1:0] count;
  logic [PIXEL_COUNT-1:0] next_shift;
  logic [COUNT_W-1:0] next_count;

  wire idle = (count == CNT_IDLE);
  wire start_taken = idle && start_s2;
  wire last_rise = (count == CNT_LAST_PIXEL);
  wire reset_end = (count == CNT_RESET_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Shift register stages

  // Stage g takes stage g-1 on a clock rise; stage 0 only loads the start
  logic [PIXEL_COUNT-1:0] stepped;

  assign stepped[0] = 1'b0;

  generate
    for (genvar g = 1; g < PIXEL_COUNT; g++) begin : g_stage
      assign stepped[g] = shift[g-1];
    end
  endgenerate

  // Encoder ORs the positions of set stages: small, but only valid while
  // the register holds a single bit, which start and clear guarantee
  function automatic logic [INDEX_W-1:0] stage_index(
    input logic [PIXEL_COUNT-1:0] stages
  );
    logic [INDEX_W-1:0] pos;
    pos = '0;
    for (int i = 0; i < PIXEL_COUNT; i++) begin
      if (stages[i]) pos = pos | INDEX_W'(i);
    end
    return pos;
  endfunction : stage_index

  // Start pulse moves one stage per pixel clock
  always_comb begin
    next_shift = shift;
    next_count = count;
    if (pclk_rise) begin
      if (last_rise) begin
        // Whole register cleared so a stray start bit cannot linger
        next_shift = '0;
        next_count = CNT_IDLE;
      end else if (start_taken) begin
        next_shift = {{(PIXEL_COUNT-1){1'b0}}, 1'b1};
        next_count = CNT_FIRST;
      end else if (!idle) begin
        next_shift = stepped;
        next_count = count + COUNT_W'(1);
      end
    end
  end

  // Retrigger while busy is ignored; the host must wait out the scan
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= '0;
      count <= CNT_IDLE;
    end else begin
      shift <= next_shift;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Freeze and integrator reset

  // Freeze wins over the clock-19 release in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_reset <= 1'b0;
      cap_connected <= 1'b1;
    end else if (hold_rise) begin
      integ_reset <= 1'b1;
      cap_connected <= 1'b0;
    end else if (pclk_rise && reset_end) begin
      integ_reset <= 1'b0;
      cap_connected <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  wire out_phase = (next_count != CNT_IDLE);
  // Stage position picks the pixel, so the shift register drives readout
  wire [INDEX_W-1:0] next_index = stage_index(next_shift);
  // Level trails a new index by one cycle; host samples at period end
  wire [LEVEL_W-1:0] next_level = out_phase ? pixel_level : '0;
  wire [INDEX_W-1:0] gated_index = out_phase ? next_index : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.aout_oe <= 1'b0;
      link.pixel_analog_out <= '0;
      link.chain_out <= 1'b0;
    end else begin
      link.aout_oe <= out_phase;
      // Driven level is don't-care when oe is low; kept at zero
      link.pixel_analog_out <= next_level;
      link.chain_out <= next_shift[PIXEL_COUNT-1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_index <= '0;
      scan_active <= 1'b0;
    end else begin
      pixel_index <= gated_index;
      scan_active <= out_phase;
    end
  end

endmodule : lasc_sensor

/* verification/lasc_link_properties.sv */
// Purpose: Link checks between sensor end and host end
// Assumes: Both ends on sys_clk; figures from the package and the notes
// Notes: Instantiated beside the link interface

`timescale 1ns/1ps

module lasc_link_properties
  import lasc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link pins
  input wire logic pix_clk,
  input wire logic scan_start,
  input wire logic hold_freeze,
  input wire logic [LEVEL_W-1:0] pixel_analog_out,
  input wire logic aout_oe,
  input wire logic chain_out
);
  // Oe falls a few cycles after the terminating rise, so allow slack
  localparam int GAP_MIN = 980;
  logic [10:0] idle_gap;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) idle_gap <= 11'h7ff;
    else if (aout_oe) idle_gap <= 11'h000;
    else if (idle_gap != 11'h7ff) idle_gap <= idle_gap + 11'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  sequence last_pixel_s;
    chain_out [*8];
  endsequence
  sequence scan_end_s;
    ##[1:1000] $fell(aout_oe);
  endsequence

  quiet_output_a: assert property (
    !aout_oe |-> pixel_analog_out == '0)
    else $error("level driven while output released");
  freeze_follows_start_a: assert property (
    hold_freeze == scan_start)
    else $error("freeze differs from start");
  start_on_clock_a: assert property (
    $rose(aout_oe) |-> pix_clk && scan_start)
    else $error("readout began without start at clock");
  start_while_low_a: assert property (
    $rose(scan_start) |-> !pix_clk)
    else $error("start raised while clock high");
  start_short_a: assert property (
    $rose(pix_clk) && scan_start |-> ##[1:60] !scan_start)
    else $error("start held past one clock");
  shift_on_clock_a: assert property (
    aout_oe && $changed(pixel_analog_out) |-> pix_clk)
    else $error("pixel changed without clock rise");
  chain_last_a: assert property (
    $rose(chain_out) |-> aout_oe ##0 last_pixel_s ##0 scan_end_s)
    else $error("chain pulse not followed by scan end");
  terminate_all_a: assert property (
    $fell(aout_oe) |-> pix_clk && $fell(chain_out))
    else $error("scan end not on clock rise with chain");
  transfer_gap_a: assert property (
    $rose(scan_start) |-> idle_gap >= GAP_MIN)
    else $error("next start too soon after scan end");
endmodule : lasc_link_properties

/* verification/lasc_tb.sv */
// Purpose: Scans through host and sensor ends joined by the link
// Assumes: Pixel level is a known function of pixel index
// Notes: Stall window fills the buffer to hold the pixel clock

`timescale 1ns/1ps

module lasc_tb;
  import lasc_pkg::*;
  localparam int STEP = 1;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic sample_ready = 1'b1;
  logic start_ready, scan_done, sample_valid;
  logic [LEVEL_W-1:0] sample_data, pixel_level;
  logic [INDEX_W-1:0] pixel_index;
  logic integ_reset, cap_connected, scan_active;
  logic stall_on = 1'b0;
  logic pc_q = 1'b0;
  logic [10:0] stall_cnt = 11'h000;
  int n_mismatch = 0;
  int checked = 0;
  int n_seen = 0;
  int n_done = 0;
  int rise_no = 200;
  int settle = 0;

  lasc_link_if link_i();
  lasc_host lasc_host_i(.sys_clk(sys_clk), .rst_n(rst_n), .link(link_i),
    .start_req(start_req), .start_ready(start_ready),
    .scan_done(scan_done), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));
  lasc_sensor lasc_sensor_i(.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link_i), .pixel_index(pixel_index), .pixel_level(pixel_level),
    .integ_reset(integ_reset), .cap_connected(cap_connected),
    .scan_active(scan_active));
  lasc_link_properties lasc_link_properties_i(.sys_clk(sys_clk),
    .rst_n(rst_n), .pix_clk(link_i.pix_clk),
    .scan_start(link_i.scan_start), .hold_freeze(link_i.hold_freeze),
    .pixel_analog_out(link_i.pixel_analog_out),
    .aout_oe(link_i.aout_oe), .chain_out(link_i.chain_out));

  always #(SYS_PERIOD_NS / 2) sys_clk = ~sys_clk;
  assign #STEP pixel_level = {pixel_index, 1'b1} ^ 8'h3c;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////
  // Ready low for long spans so the buffer fills and holds the clock
  always @(posedge sys_clk) begin
    stall_cnt <= stall_cnt + 11'h001;
    sample_ready <= #STEP !(stall_on && stall_cnt < 11'h4b0);
    if (rst_n && sample_valid === 1'b1 && sample_ready) begin
      check("sample", sample_data, {n_seen[6:0], 1'b1} ^ 8'h3c);
      n_seen++;
    end
    if (scan_done === 1'b1) n_done++;
  end

  // Array state checked a few cycles after each pixel clock rise
  always @(posedge sys_clk) begin
    pc_q <= link_i.pix_clk;
    if (!rst_n) begin
      settle = 0;
      rise_no = 200;
    end else if (link_i.pix_clk && !pc_q) begin
      rise_no = link_i.scan_start ? 1 : rise_no + 1;
      settle = 6;
    end else if (settle > 0) begin
      settle--;
      if (settle == 0 && rise_no <= 129) begin
        check("integ_reset", integ_reset, rise_no < CNT_INTEG_START);
        check("cap_connected", cap_connected,
              rise_no >= CNT_INTEG_START);
        check("aout_oe", link_i.aout_oe, rise_no <= 128);
        check("scan_active", scan_active, rise_no <= 128);
        check("chain_out", link_i.chain_out, rise_no == 128);
        if (rise_no <= 128) check("index", pixel_index, rise_no - 1);
      end
    end
  end

  task automatic run_scan(input string name, input int scans);
    int d0;
    int waited;
    d0 = n_done;
    waited = 0;
    @(posedge sys_clk);
    check("start_ready", start_ready, 1'b1);
    #STEP start_req = 1'b1;
    @(posedge sys_clk);
    #STEP start_req = 1'b0;
    check("start busy", start_ready, 1'b0);
    while (n_done == d0 && waited < 30000) begin
      @(posedge sys_clk);
      waited++;
    end
    check("scan_done", n_done, d0 + 1);
    waited = 0;
    while (sample_valid !== 1'b0 && waited < 3000) begin
      @(posedge sys_clk);
      waited++;
    end
    check("samples", n_seen, scans * PIXEL_COUNT);
    $display("Test %s done", name);
  endtask : run_scan

  initial begin
    repeat (2) @(posedge sys_clk);
    #STEP rst_n = 1'b1;
    check("idle oe", link_i.aout_oe, 1'b0);
    check("idle cap", cap_connected, 1'b1);
    run_scan("single", 1);
    stall_on = 1'b1;
    run_scan("stalled", 2);
    run_scan("back_to_back", 3);
    stall_on = 1'b0;
    @(posedge sys_clk);
    #STEP start_req = 1'b1;
    @(posedge sys_clk);
    #STEP start_req = 1'b0;
    repeat (3000) @(posedge sys_clk);
    #STEP rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    check("reset oe", link_i.aout_oe, 1'b0);
    check("reset chain", link_i.chain_out, 1'b0);
    #STEP rst_n = 1'b1;
    n_seen = 0;
    run_scan("after_reset", 1);
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    $display("Watchdog expired");
    report_and_stop();
  end
endmodule : lasc_tb
